//--- pkg/lcd_ctrl_pkg.sv
// Constants and types of the display driver control block
package lcd_ctrl_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_NS = 50;
  // Internal oscillator tick period, in ns
  localparam int RC_TICK_NS = 200;
  localparam int RC_TICK_CYC = (RC_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RC_TICK_LAST = 8'(RC_TICK_CYC - 1);
  // Last oscillator tick of each scan line's dwell (8 ticks per line)
  localparam logic [3:0] SCAN_LINE_LAST = 4'h7;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DISP_OFS = 4'h4;
  localparam logic [3:0] KEY_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;
  localparam int CTRL_W = 17;
  localparam int DISP_W = 16;

  typedef struct packed {
    logic clock_source_select;
    logic [2:0] frame_div;
    logic duty_select;
    logic bias_select;
    logic segment_blank;
    logic [2:0] port_select;
    logic [1:0] keyseg_select;
    logic scan_disable;
    logic [2:0] standby_level;
    logic sleep_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = ctrl_t'(17'h00000);
  localparam logic [15:0] DISP_RST = 16'h0000;

  // ***************************************************
  // Key scan
  // ***************************************************
  localparam int NUM_LINES = 6;
  localparam int KEYS_PER_LINE = 5;
  localparam int KEY_W = NUM_LINES * KEYS_PER_LINE;
  localparam int NUM_PORTS = 4;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01
  } scan_state_t;

  // ***************************************************
  // Frame divider
  // ***************************************************
  localparam logic [2:0] FRAME_768 = 3'h0;
  localparam logic [2:0] FRAME_576 = 3'h1;
  localparam logic [2:0] FRAME_384 = 3'h2;
  localparam logic [2:0] FRAME_288 = 3'h3;
  localparam logic [2:0] FRAME_192 = 3'h4;
  localparam logic [9:0] DIV_768 = 10'h300;
  localparam logic [9:0] DIV_576 = 10'h240;
  localparam logic [9:0] DIV_384 = 10'h180;
  localparam logic [9:0] DIV_288 = 10'h120;
  localparam logic [9:0] DIV_192 = 10'h0C0;

endpackage

//--- hdl/frame_divider.sv
// Frame rate divider counting oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module frame_divider
  import lcd_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [9:0] div_i,
  output logic frame_tick_o
);

  logic [9:0] count_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= 10'h000;
      frame_tick_o <= 1'b0;
    end else begin
      frame_tick_o <= 1'b0;
      if (tick_i) begin
        // Divisor change applies at the next wrap or sooner
        if (count_ff >= div_i - 10'h001) begin
          count_ff <= 10'h000;
          frame_tick_o <= 1'b1;
        end else begin
          count_ff <= count_ff + 10'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/lcd_key_scan_control_decode.sv
// Control decode, key scan and pin muxing of the display driver
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcd_key_scan_control_decode
  import lcd_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic [KEYS_PER_LINE-1:0] key_in_i,
  output logic [NUM_LINES-1:0] key_scan_o,
  output logic [2:0] key_pin_is_seg_o,
  output logic [NUM_PORTS-1:0] port_is_gpo_o,
  output logic [NUM_PORTS-1:0] port_level_o,
  output logic osc_run_o,
  output logic ext_clk_accept_o,
  output logic lcd_drive_en_o,
  output logic seg_blank_o,
  output logic bias_half_o,
  output logic duty_third_o,
  output logic com4_is_seg_o,
  output logic frame_o,
  output logic serial_out_oe_o
);

  // ***************************************************
  // Register bus
  // ***************************************************
  ctrl_t ctrl_ff;
  logic [DISP_W-1:0] disp_ff;
  logic [KEY_W-1:0] keydata_ff;
  logic key_req_ff;
  scan_state_t state_ff;
  logic [31:0] wmask;
  logic bus_req;
  logic bus_wr;
  logic key_read;
  logic scan_done;
  logic scan_found;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign key_read = bus_req & ~wb_we_i & (wb_adr_i == KEY_OFS);
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      disp_ff <= DISP_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == CTRL_OFS) begin
        ctrl_ff <= ctrl_t'((ctrl_ff & ~wmask[CTRL_W-1:0])
                           | (wb_dat_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]));
      end
      if (wb_adr_i == DISP_OFS) begin
        disp_ff <= (disp_ff & ~wmask[DISP_W-1:0])
                   | (wb_dat_i[DISP_W-1:0] & wmask[DISP_W-1:0]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req & ~wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_OFS: wb_dat_o <= {15'h0000, ctrl_ff};
        DISP_OFS: wb_dat_o <= {16'h0000, disp_ff};
        KEY_OFS: wb_dat_o <= {2'h0, keydata_ff};
        STAT_OFS: wb_dat_o <= {29'h00000000,
                               ctrl_ff.sleep_select & (state_ff == SCAN_IDLE),
                               state_ff == SCAN_RUN, key_req_ff};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic [KEYS_PER_LINE-1:0] key_meta_ff;
  logic [KEYS_PER_LINE-1:0] key_sync_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_meta_ff <= '0;
      key_sync_ff <= '0;
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      key_meta_ff <= key_in_i;
      key_sync_ff <= key_meta_ff;
      ext_meta_ff <= ext_clk_i;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  // ***************************************************
  // Clock source and oscillator ticks
  // ***************************************************
  logic clk_on;
  logic rc_on;
  logic ext_on;
  logic [7:0] rc_cnt_ff;
  logic tick;

  // Sleep stops the clock, but a running scan still needs it
  assign clk_on = ~ctrl_ff.sleep_select | (state_ff == SCAN_RUN);
  assign rc_on = clk_on & ~ctrl_ff.clock_source_select;
  assign ext_on = clk_on & ctrl_ff.clock_source_select;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_cnt_ff <= 8'h00;
    end else if (!rc_on || rc_cnt_ff == RC_TICK_LAST) begin
      rc_cnt_ff <= 8'h00;
    end else begin
      rc_cnt_ff <= rc_cnt_ff + 8'h01;
    end
  end

  assign tick = (rc_on & (rc_cnt_ff == RC_TICK_LAST))
                | (ext_on & ext_sync_ff & ~ext_prev_ff);

  // ***************************************************
  // Frame rate
  // ***************************************************
  logic [9:0] frame_div;
  logic frame_tick;

  always_comb begin
    unique case (ctrl_ff.frame_div)
      FRAME_768: frame_div = DIV_768;
      FRAME_576: frame_div = DIV_576;
      FRAME_384: frame_div = DIV_384;
      FRAME_288: frame_div = DIV_288;
      FRAME_192: frame_div = DIV_192;
      // Unlisted codes fall back to the slowest rate
      default: frame_div = DIV_768;
    endcase
  end

  frame_divider u_frame_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick & ~ctrl_ff.sleep_select),
    .div_i(frame_div),
    .frame_tick_o(frame_tick)
  );

  // ***************************************************
  // Key scan
  // ***************************************************
  logic [NUM_LINES-1:0] eligible;
  logic [2:0] line_ff;
  logic [3:0] dwell_ff;
  logic any_press;

  // Lines held high in standby and not lent to segments
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      assign eligible[gi] = (3'(gi) >= ctrl_ff.standby_level)
                            & (3'(gi) >= {1'b0, ctrl_ff.keyseg_select});
    end
  endgenerate

  assign any_press = (|key_sync_ff) & (|eligible);
  assign scan_done = (state_ff == SCAN_RUN) & tick
                     & (dwell_ff == SCAN_LINE_LAST)
                     & (line_ff == 3'(NUM_LINES - 1));
  assign scan_found = |keydata_ff | (eligible[NUM_LINES-1] & (|key_sync_ff));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SCAN_IDLE;
      line_ff <= 3'h0;
      dwell_ff <= 4'h0;
    end else if (ctrl_ff.scan_disable) begin
      state_ff <= SCAN_IDLE;
      line_ff <= 3'h0;
      dwell_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        SCAN_IDLE: begin
          if (any_press) begin
            state_ff <= SCAN_RUN;
          end
          line_ff <= 3'h0;
          dwell_ff <= 4'h0;
        end
        SCAN_RUN: begin
          if (tick) begin
            if (dwell_ff == SCAN_LINE_LAST) begin
              dwell_ff <= 4'h0;
              if (line_ff == 3'(NUM_LINES - 1)) begin
                state_ff <= SCAN_IDLE;
                line_ff <= 3'h0;
              end else begin
                line_ff <= line_ff + 3'h1;
              end
            end else begin
              dwell_ff <= dwell_ff + 4'h1;
            end
          end
        end
        default: state_ff <= SCAN_IDLE;
      endcase
    end
  end

  // Key data captured at the end of each line's dwell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keydata_ff <= '0;
    end else if (ctrl_ff.scan_disable) begin
      keydata_ff <= '0;
    end else if (state_ff == SCAN_IDLE && any_press) begin
      keydata_ff <= '0;
    end else if (state_ff == SCAN_RUN && tick
                 && dwell_ff == SCAN_LINE_LAST) begin
      keydata_ff[line_ff*KEYS_PER_LINE +: KEYS_PER_LINE] <=
        eligible[line_ff] ? key_sync_ff : '0;
    end
  end

  // Finished scan outranks a read that clears in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_req_ff <= 1'b0;
    end else if (ctrl_ff.scan_disable) begin
      key_req_ff <= 1'b0;
    end else if (scan_done && scan_found) begin
      key_req_ff <= 1'b1;
    end else if (key_read) begin
      key_req_ff <= 1'b0;
    end
  end

  // ***************************************************
  // Pin outputs
  // ***************************************************
  logic [NUM_LINES-1:0] nxt_key_scan;
  logic [NUM_PORTS-1:0] nxt_port_gpo;
  logic [NUM_PORTS-1:0] nxt_port_level;

  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_scan_out
      assign nxt_key_scan[gi] = (state_ff == SCAN_RUN)
        ? (eligible[gi] & (line_ff == 3'(gi)))
        : (3'(gi) >= ctrl_ff.standby_level);
    end
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign nxt_port_gpo[gi] = 3'(gi) < ctrl_ff.port_select;
      assign nxt_port_level[gi] = nxt_port_gpo[gi]
        & (ctrl_ff.duty_select ? disp_ff[gi*3] : disp_ff[gi*4]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_scan_o <= '1;
      key_pin_is_seg_o <= 3'h0;
      port_is_gpo_o <= '0;
      port_level_o <= '0;
    end else begin
      key_scan_o <= nxt_key_scan;
      key_pin_is_seg_o <= {ctrl_ff.keyseg_select == 2'h3,
                           ctrl_ff.keyseg_select >= 2'h2,
                           ctrl_ff.keyseg_select != 2'h0};
      port_is_gpo_o <= nxt_port_gpo;
      port_level_o <= nxt_port_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_run_o <= 1'b0;
      ext_clk_accept_o <= 1'b0;
      lcd_drive_en_o <= 1'b0;
      seg_blank_o <= 1'b0;
      bias_half_o <= 1'b0;
      duty_third_o <= 1'b0;
      com4_is_seg_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      osc_run_o <= rc_on;
      ext_clk_accept_o <= ext_on;
      lcd_drive_en_o <= ~ctrl_ff.sleep_select;
      seg_blank_o <= ctrl_ff.segment_blank;
      bias_half_o <= ctrl_ff.bias_select;
      duty_third_o <= ctrl_ff.duty_select;
      com4_is_seg_o <= ctrl_ff.duty_select;
      serial_out_oe_o <= key_req_ff;
    end
  end

  // Common/segment waveforms held low in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i || ctrl_ff.sleep_select) begin
      frame_o <= 1'b0;
    end else if (frame_tick) begin
      frame_o <= ~frame_o;
    end
  end

endmodule
`default_nettype wire

//--- dv/lcd_ctrl_props.sv
// Checker of the control decode outputs
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_props
  import lcd_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] key_pin_is_seg_o,
  input wire logic [NUM_PORTS-1:0] port_is_gpo_o,
  input wire logic [NUM_PORTS-1:0] port_level_o,
  input wire logic lcd_drive_en_o,
  input wire logic seg_blank_o,
  input wire logic bias_half_o,
  input wire logic duty_third_o,
  input wire logic com4_is_seg_o,
  input wire logic frame_o,
  input wire logic serial_out_oe_o
);
  // ***************************************************
  // Properties
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ctrl;
  // Only full-word writes, so every field is known
  assign wr_ctrl = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i &
    (wb_adr_i == CTRL_OFS) & (wb_sel_i == 4'hF);
  property p_sleep_frame;
    !lcd_drive_en_o |-> !frame_o;
  endproperty
  a_sleep_frame: assert property (p_sleep_frame)
    else $error("frame output active while drive off");
  property p_sleep_write;
    wr_ctrl && wb_dat_i[0] |=> ##1 !lcd_drive_en_o;
  endproperty
  a_sleep_write: assert property (p_sleep_write)
    else $error("sleep write left drive on");
  property p_com4;
    wr_ctrl |=> com4_is_seg_o == $past(wb_dat_i[12]);
  endproperty
  a_com4: assert property (p_com4)
    else $error("fourth common pin disagrees with duty");
  property p_duty_write;
    wr_ctrl |=> duty_third_o == $past(wb_dat_i[12]);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty output does not follow write");
  property p_bias_write;
    wr_ctrl |=> bias_half_o == $past(wb_dat_i[11]);
  endproperty
  a_bias_write: assert property (p_bias_write)
    else $error("bias output does not follow write");
  property p_blank_write;
    wr_ctrl |=> seg_blank_o == $past(wb_dat_i[10]);
  endproperty
  a_blank_write: assert property (p_blank_write)
    else $error("blank output does not follow write");
  property p_port_level;
    (port_level_o & ~port_is_gpo_o) == 4'h0;
  endproperty
  a_port_level: assert property (p_port_level)
    else $error("level on a pin that is not a port");
  property p_port_therm;
    port_is_gpo_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
  endproperty
  a_port_therm: assert property (p_port_therm)
    else $error("port pins not a leading run");
  property p_keyseg_therm;
    key_pin_is_seg_o inside {3'h0, 3'h1, 3'h3, 3'h7};
  endproperty
  a_keyseg_therm: assert property (p_keyseg_therm)
    else $error("segment pins not a leading run");
  property p_disable_clear;
    wr_ctrl && wb_dat_i[4] |=> ##1 !serial_out_oe_o;
  endproperty
  a_disable_clear: assert property (p_disable_clear)
    else $error("request kept after scan disable");
endmodule
bind lcd_key_scan_control_decode lcd_ctrl_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .key_pin_is_seg_o(key_pin_is_seg_o), .port_is_gpo_o(port_is_gpo_o),
  .port_level_o(port_level_o), .lcd_drive_en_o(lcd_drive_en_o),
  .seg_blank_o(seg_blank_o), .bias_half_o(bias_half_o),
  .duty_third_o(duty_third_o), .com4_is_seg_o(com4_is_seg_o),
  .frame_o(frame_o), .serial_out_oe_o(serial_out_oe_o));
`default_nettype wire

//--- dv/key_matrix_model.sv
// Key matrix partner joining scan lines to return inputs
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model
  import lcd_ctrl_pkg::*;
(
  input wire logic [NUM_LINES-1:0] key_scan_i,
  input wire logic [KEY_W-1:0] pressed_i,
  output logic [KEYS_PER_LINE-1:0] key_ret_o
);
  // ***************************************************
  // Matrix
  // ***************************************************
  // Open keys leave returns at the pull-down level
  always_comb begin
    key_ret_o = '0;
    for (int l = 0; l < NUM_LINES; l++) begin
      for (int k = 0; k < KEYS_PER_LINE; k++) begin
        key_ret_o[k] = key_ret_o[k] |
          (key_scan_i[l] & pressed_i[l*KEYS_PER_LINE+k]);
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/lcd_key_scan_control_decode_tb_top.sv
// Self-checking bench of the control decode block
`timescale 1ns/1ps
`default_nettype none
module lcd_key_scan_control_decode_tb_top import lcd_ctrl_pkg::*;;
  // ***************************************************
  // Signals and helpers
  // ***************************************************
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ext_clk = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0, plev, gpo, g4, e4;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [29:0] pressed = 30'h0;
  logic [4:0] key_in;
  logic [5:0] kscan, e6, m6;
  logic [2:0] kps;
  logic ack, osc, eacc, lcd_en, blank, bias, duty, com4, frame, soe;
  logic seen, bad;
  logic [15:0] disp;
  ctrl_t cw;
  int err_total = 0, n_checks = 0, seed = 18, c, i;
  int dv[5] = '{768, 576, 384, 288, 192};
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) ext_clk <= ~ext_clk;
  lcd_key_scan_control_decode dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_clk_i(ext_clk), .key_in_i(key_in), .key_scan_o(kscan),
    .key_pin_is_seg_o(kps), .port_is_gpo_o(gpo), .port_level_o(plev),
    .osc_run_o(osc), .ext_clk_accept_o(eacc), .lcd_drive_en_o(lcd_en),
    .seg_blank_o(blank), .bias_half_o(bias), .duty_third_o(duty),
    .com4_is_seg_o(com4), .frame_o(frame), .serial_out_oe_o(soe));
  key_matrix_model u_keys (.key_scan_i(kscan), .pressed_i(pressed),
    .key_ret_o(key_in));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // A missing answer is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task wctl;
    wb(1'b1, CTRL_OFS, 32'(cw));
    repeat (3) @(posedge clk_i);
  endtask
  // Watches scan lines while waiting for a key request
  task wreq;
    c = 0;
    seen = 0;
    bad = 0;
    while (soe !== 1'b1 && c < 1000) begin
      @(posedge clk_i);
      c++;
      if (osc === 1'b1) seen = 1;
      if (kscan[1:0] !== 2'b00) bad = 1;
    end
  endtask
  task wchg;
    logic old;
    old = frame;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (frame === old && c < 5000);
  endtask
  initial begin
    #(80000 * 50);
    chk(32'h0, 32'h1);
    tally_and_finish;
  end
  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(kscan, 6'h3F);
    chk({lcd_en, osc}, 2'h3);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 24; i++) begin
      cw = ctrl_t'(17'h0);
      cw.standby_level = (i < 7) ? 3'(i) : 3'({$random(seed)} % 7);
      cw.port_select = (i < 5) ? 3'(i) : 3'({$random(seed)} % 5);
      cw.frame_div = 3'({$random(seed)} % 5);
      cw.keyseg_select = 2'($random(seed));
      {cw.sleep_select, cw.segment_blank} = 2'($random(seed));
      {cw.bias_select, cw.duty_select} = 2'($random(seed));
      cw.scan_disable = 1'b1;
      disp = 16'($random(seed));
      wb(1'b1, DISP_OFS, 32'(disp));
      wctl;
      wb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'(cw));
      wb(1'b0, DISP_OFS, 32'h0);
      chk(rd, 32'(disp));
      m6 = 6'((7'h1 << cw.keyseg_select) - 7'h1);
      e6 = 6'h3F << cw.standby_level;
      chk(kscan | m6, e6 | m6);
      chk(kps, 3'(m6));
      g4 = 4'((5'h1 << cw.port_select) - 5'h1);
      e4 = cw.duty_select ? {disp[9], disp[6], disp[3], disp[0]} :
        {disp[12], disp[8], disp[4], disp[0]};
      chk(gpo, g4);
      chk(plev, e4 & g4);
      chk({lcd_en, osc}, {2{~cw.sleep_select}});
      chk({blank, bias}, {cw.segment_blank, cw.bias_select});
      chk({duty, com4}, {2{cw.duty_select}});
    end
    cw = ctrl_t'(17'h0);
    cw.clock_source_select = 1'b1;
    wctl;
    chk({eacc, osc}, 2'h2);
    cw.sleep_select = 1'b1;
    wctl;
    chk(eacc, 1'b0);
    cw = ctrl_t'(17'h0);
    for (i = 0; i < 5; i++) begin
      cw.frame_div = 3'(i);
      wctl;
      repeat (3) wchg;
      chk(c, dv[i] * RC_TICK_CYC);
    end
    // Sleep with lines 0 and 1 parked low
    cw.sleep_select = 1'b1;
    cw.standby_level = 3'h2;
    wctl;
    pressed <= 30'h1 << 17;
    wreq;
    chk({soe, seen, bad}, 3'h6);
    pressed <= 30'h0;
    wb(1'b0, KEY_OFS, 32'h0);
    chk(rd, 32'h1 << 17);
    repeat (3) @(posedge clk_i);
    chk(soe, 1'b0);
    pressed <= 30'h1 << 2;
    wreq;
    chk(soe, 1'b0);
    pressed <= 30'h1 << 17;
    wreq;
    chk(soe, 1'b1);
    // Request pending; either scanning or asleep and idle
    wb(1'b0, STAT_OFS, 32'h0);
    chk({rd[31:3], rd[2] ^ rd[1], rd[0]}, 32'h3);
    cw.scan_disable = 1'b1;
    wctl;
    chk(soe, 1'b0);
    wb(1'b0, KEY_OFS, 32'h0);
    chk(rd, 32'h0);
    pressed <= 30'h1 << 25;
    wreq;
    chk(soe, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
